// *** hdl/fdr_diag_record.sv ***
// Diagnosis record framer with register port and interrupt
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
// What this block does
// - Record fills the first 32 bytes of the diagnosis area.
// - Bytes 0-5 standard diagnosis; bytes 4 and 5 hold unit id.
// - Byte 6 carries the diagnosis data length.
// - Byte 10 holds the highest connected head address.
// - Bytes 12-22 hold ASCII text of the last failed command.
// - Byte 11 box bits: 0 self-test, 1 ambient, 3 parameter, 4 write.
// - Box bit 2 set when any head communication fails.
// - Bytes 23-30 hold per-head error bytes in head order.
// - Head bit 6 set when registered but not connected.
module fdr_diag_record #(
  parameter logic [15:0] UNIT_ID = fdr_pkg::UNIT_ID_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             irq,
  input  wire logic [4:0]  box_err,
  input  wire logic [7:0]  head_comm_fail,
  input  wire logic [7:0]  head_connected,
  input  wire logic [7:0]  head_registered,
  input  wire logic [39:0] head_err,
  input  wire logic [7:0]  std_diag0,
  input  wire logic [7:0]  std_diag1,
  input  wire logic [7:0]  std_diag2,
  input  wire logic [7:0]  std_diag3,
  input  wire logic        cmd_fail,
  input  wire logic [87:0] cmd_text,
  output logic [255:0]     rec_q
);
  // =========================================================
  // Record assembly
  // =========================================================
  logic [7:0]   box_q;
  logic [7:0]   high_q;
  logic [87:0]  cmd_q;
  logic [63:0]  heads_q;
  logic [31:0]  std_q;
  logic [7:0]   status_q;
  logic [7:0]   mask_q;
  logic [7:0]   ev;
  logic [7:0]   box_prev_q;

  // Reserved and spare bit positions of a head byte
  localparam int HD_RSV   = 5;
  localparam int HD_SPARE = 7;

  function automatic logic [7:0] top_head(input logic [7:0] c);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < fdr_pkg::HEADS; i++)
      if (c[i]) r = 8'(i + 1);
    return r;
  endfunction

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      box_q   <= 8'h00;
      high_q  <= 8'h00;
      heads_q <= 64'h0;
      std_q   <= 32'h0;
    end
    else if (ce)
    begin
      std_q  <= {std_diag3, std_diag2, std_diag1, std_diag0};
      high_q <= top_head(head_connected);
      box_q  <= 8'h00;
      box_q[fdr_pkg::BX_SELFTEST] <= box_err[fdr_pkg::BX_SELFTEST];
      box_q[fdr_pkg::BX_AMBIENT]  <= box_err[fdr_pkg::BX_AMBIENT];
      box_q[fdr_pkg::BX_PARAM]    <= box_err[fdr_pkg::BX_PARAM];
      box_q[fdr_pkg::BX_REGWR]    <= box_err[fdr_pkg::BX_REGWR];
      box_q[fdr_pkg::BX_HEADCOMM] <= box_err[fdr_pkg::BX_HEADCOMM]
                                     | (|head_comm_fail);
      for (int h = 0; h < fdr_pkg::HEADS; h++)
      begin
        heads_q[h*8 +: 8] <= {1'b0,
          head_registered[h] & ~head_connected[h],
          1'b0,
          head_err[h*5 +: 5]};
      end
    end
  end

  // Only a failing answer replaces the stored command text
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cmd_q <= 88'h0;
    else if (ce && cmd_fail)
      cmd_q <= cmd_text;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rec_q <= '0;
    else if (ce)
    begin
      rec_q <= '0;
      rec_q[31:0]    <= std_q;
      rec_q[39:32]   <= UNIT_ID[15:8];
      rec_q[47:40]   <= UNIT_ID[7:0];
      rec_q[55:48]   <= fdr_pkg::DIAG_SIZE;
      rec_q[87:80]   <= high_q;
      rec_q[95:88]   <= box_q;
      for (int k = 0; k < fdr_pkg::CMD_LEN; k++)
        rec_q[(fdr_pkg::B_CMD0+k)*8 +: 8] <= cmd_q[k*8 +: 8];
      rec_q[247:184] <= heads_q;
    end
  end

  // =========================================================
  // Interrupt: one sticky bit per box error rising
  // =========================================================
  assign ev = {3'b000, box_q[4:0] & ~box_prev_q[4:0]};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_q   <= 8'h00;
      box_prev_q <= 8'h00;
      mask_q     <= 8'h00;
      irq        <= 1'b0;
    end
    else if (ce)
    begin
      box_prev_q <= box_q;
      // Set wins over a same-cycle write-one clear
      if (wr && addr == fdr_pkg::A_STATUS)
        status_q <= (status_q & ~wdata[7:0]) | ev;
      else
        status_q <= status_q | ev;
      if (wr && addr == fdr_pkg::A_MASK)
        mask_q <= wdata[7:0];
      irq <= |(status_q & mask_q);
    end
  end

  // =========================================================
  // Register read port
  // =========================================================
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 32'h0;
    else if (ce)
    begin
      rdata <= 32'h0;
      if (rd)
      begin
        // Only eight record words exist; the rest of the span reads zero
        if (addr < 8'(fdr_pkg::REC_LEN))
          rdata <= rec_q[addr[4:2]*32 +: 32];
        else if (addr == fdr_pkg::A_STATUS)
          rdata <= {24'h0, status_q};
        else if (addr == fdr_pkg::A_MASK)
          rdata <= {24'h0, mask_q};
        else if (addr == fdr_pkg::A_ID)
          rdata <= {16'h0, UNIT_ID};
      end
    end
  end

  // =========================================================
  // Checks
  // =========================================================
  AST_SIZE: assert property (@(posedge clk) disable iff (rst)
    ce |=> rec_q[55:48] == fdr_pkg::DIAG_SIZE)
    else $error("size byte wrong");
  AST_RSV: assert property (@(posedge clk) disable iff (rst)
    rec_q[79:56] == 24'h0 && rec_q[189] == 1'b0)
    else $error("reserved not zero");
  AST_COMM: assert property (@(posedge clk) disable iff (rst)
    (ce && |head_comm_fail) ##1 ce [*2] |-> rec_q[90])
    else $error("comm bit missing");
  AST_CABLE: assert property (@(posedge clk) disable iff (rst)
    (ce && head_registered[0] && !head_connected[0]) ##1 ce [*2]
    |-> rec_q[190])
    else $error("cable bit missing");
  AST_CMD: assert property (@(posedge clk) disable iff (rst)
    (ce && cmd_fail) ##1 ce [*2]
    |-> rec_q[103:96] == $past(cmd_text[7:0], 2))
    else $error("command text wrong");
  AST_ID: assert property (@(posedge clk) disable iff (rst)
    ce |=> rec_q[47:32] == {UNIT_ID[7:0], UNIT_ID[15:8]})
    else $error("unit id wrong");
  AST_TAIL: assert property (@(posedge clk) disable iff (rst)
    rec_q[255:248] == 8'h00)
    else $error("byte 31 not zero");
  AST_HIGH: assert property (@(posedge clk) disable iff (rst)
    (ce && head_connected == 8'h80) ##1 ce [*2] |-> rec_q[87:80] == 8'h08)
    else $error("highest head wrong");

  // =========================================================
  // Box byte checks, two-stage latency
  // =========================================================
  for (genvar b = 0; b < 5; b++)
  begin : g_box_chk
    if (b != fdr_pkg::BX_HEADCOMM)
    begin : g_plain
      AST_BOX_BIT: assert property (@(posedge clk) disable iff (rst)
        ce ##1 ce |=> rec_q[fdr_pkg::B_BOXERR*8 + b]
                      == $past(box_err[b], 2))
        else $error("box error bit wrong");
    end
  end

  AST_COMM_ANY: assert property (@(posedge clk) disable iff (rst)
    ce ##1 ce |=> rec_q[fdr_pkg::B_BOXERR*8 + fdr_pkg::BX_HEADCOMM]
      == $past(box_err[fdr_pkg::BX_HEADCOMM] | (|head_comm_fail), 2))
    else $error("comm bit does not follow inputs");

  AST_BOX_TOP: assert property (@(posedge clk) disable iff (rst)
    rec_q[fdr_pkg::B_BOXERR*8+5 +: 3] == 3'h0)
    else $error("box spare bits not zero");

  AST_STD: assert property (@(posedge clk) disable iff (rst)
    ce ##1 ce |=> rec_q[31:0]
      == $past({std_diag3, std_diag2, std_diag1, std_diag0}, 2))
    else $error("standard bytes wrong");

  // =========================================================
  // Head byte checks
  // =========================================================
  for (genvar g = 0; g < fdr_pkg::HEADS; g++)
  begin : g_head_chk
    AST_HEAD_BITS: assert property (@(posedge clk) disable iff (rst)
      ce ##1 ce |=> rec_q[(fdr_pkg::B_HEAD0+g)*8 +: 5]
                    == $past(head_err[g*5 +: 5], 2))
      else $error("head error bits wrong");

    AST_HEAD_CAB: assert property (@(posedge clk) disable iff (rst)
      ce ##1 ce |=> rec_q[(fdr_pkg::B_HEAD0+g)*8 + fdr_pkg::HD_CABLE]
        == $past(head_registered[g] & ~head_connected[g], 2))
      else $error("cable break bit wrong");

    AST_HEAD_RSV: assert property (@(posedge clk) disable iff (rst)
      rec_q[(fdr_pkg::B_HEAD0+g)*8 + HD_RSV] == 1'b0
      && rec_q[(fdr_pkg::B_HEAD0+g)*8 + HD_SPARE] == 1'b0)
      else $error("head reserved bit set");
  end

  // =========================================================
  // Command text checks, every byte
  // =========================================================
  for (genvar k = 0; k < fdr_pkg::CMD_LEN; k++)
  begin : g_cmd_chk
    AST_CMD_BYTE: assert property (@(posedge clk) disable iff (rst)
      (ce && cmd_fail) ##1 ce [*2]
      |-> rec_q[(fdr_pkg::B_CMD0+k)*8 +: 8] == $past(cmd_text[k*8 +: 8], 2))
      else $error("command byte wrong");
  end

  // =========================================================
  // Register port and interrupt checks
  // =========================================================
  AST_RD_IDLE: assert property (@(posedge clk) disable iff (rst)
    ce && !rd |=> rdata == 32'h0)
    else $error("read data without strobe");

  AST_RD_ID: assert property (@(posedge clk) disable iff (rst)
    ce && rd && addr == fdr_pkg::A_ID |=> rdata == {16'h0, UNIT_ID})
    else $error("unit id read wrong");

  AST_RD_HOLE: assert property (@(posedge clk) disable iff (rst)
    ce && rd && addr >= 8'(fdr_pkg::REC_LEN) && addr < fdr_pkg::REC_SPAN
    |=> rdata == 32'h0)
    else $error("hole in record span not zero");

  AST_MASK_WR: assert property (@(posedge clk) disable iff (rst)
    ce && wr && addr == fdr_pkg::A_MASK |=> mask_q == $past(wdata[7:0]))
    else $error("mask write lost");

  AST_STICKY: assert property (@(posedge clk) disable iff (rst)
    ce && !(wr && addr == fdr_pkg::A_STATUS)
    |=> (status_q & $past(status_q)) == $past(status_q))
    else $error("status bit lost without clear");

  AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
    ce && ev[0] |=> status_q[0])
    else $error("event lost against clear");

  AST_IRQ: assert property (@(posedge clk) disable iff (rst)
    ce |=> irq == |($past(status_q) & $past(mask_q)))
    else $error("interrupt level wrong");

  // Frozen clock enable must hold the record, status, read data and interrupt
  AST_FREEZE: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(rec_q) && $stable(status_q) && $stable(rdata)
            && $stable(irq))
    else $error("state moved while frozen");

  CV_IRQ: cover property (@(posedge clk) disable iff (rst) irq);
  CV_FRZ: cover property (@(posedge clk) disable iff (rst) !ce);
  CV_CLR: cover property (@(posedge clk) disable iff (rst)
    ce && wr && addr == fdr_pkg::A_STATUS && (|status_q));
  CV_CMD: cover property (@(posedge clk) disable iff (rst) ce && cmd_fail);
  CV_CAB: cover property (@(posedge clk) disable iff (rst) rec_q[190]);
endmodule // fdr_diag_record

// *** inc/fdr_pkg.sv ***
// Constants for the fieldbus diagnosis record framer
package fdr_pkg;
  localparam int          REC_LEN      = 32;
  localparam int          HEADS        = 8;
  localparam int          CMD_LEN      = 11;
  localparam logic [7:0]  STD_LEN      = 8'h06;
  localparam int          B_SIZE       = 6;
  localparam int          B_HIGH       = 10;
  localparam int          B_BOXERR     = 11;
  localparam int          B_CMD0       = 12;
  localparam int          B_HEAD0      = 23;
  localparam int          B_ID_HI      = 4;
  localparam int          B_ID_LO      = 5;
  localparam logic [7:0]  DIAG_SIZE    = 8'h20;
  // Box error bits
  localparam int          BX_SELFTEST  = 0;
  localparam int          BX_AMBIENT   = 1;
  localparam int          BX_HEADCOMM  = 2;
  localparam int          BX_PARAM     = 3;
  localparam int          BX_REGWR     = 4;
  // Head error bits
  localparam int          HD_OBJ       = 0;
  localparam int          HD_INT       = 1;
  localparam int          HD_PARAM     = 2;
  localparam int          HD_REGWR     = 3;
  localparam int          HD_SELFTEST  = 4;
  localparam int          HD_CABLE     = 6;
  // Register map, word offsets in bytes
  localparam logic [7:0]  A_REC        = 8'h00;
  localparam logic [7:0]  A_STATUS     = 8'h80;
  localparam logic [7:0]  A_MASK       = 8'h84;
  localparam logic [7:0]  A_CMD        = 8'h88;
  localparam logic [7:0]  A_ID         = 8'h8c;
  localparam logic [7:0]  REC_SPAN     = 8'h80;
  localparam logic [15:0] UNIT_ID_DEF  = 16'h1234; // Arbitrary value
endpackage

// *** dv/fdr_master_model.sv ***
// Fieldbus master model reading the diagnosis record
`timescale 1ns/1ps
module fdr_master_model (
  input  wire logic [255:0] rec,
  output logic      [7:0]   valid_mask,
  output logic              size_ok
);
  // Heads above the highest address are ignored
  always_comb
  begin
    valid_mask = 8'h00;
    for (int h = 0; h < 8; h++)
      valid_mask[h] = (h < rec[87:80]);
    size_ok = (rec[55:48] == fdr_pkg::DIAG_SIZE);
  end
endmodule // fdr_master_model

// *** dv/tb.sv ***
// Self-checking testbench for the diagnosis record framer
`timescale 1ns/1ps
module tb;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          ce = 1'b1;
  logic          wr = 1'b0;
  logic          rd = 1'b0;
  logic          cmd_fail = 1'b0;
  logic [7:0]    addr = 8'h00;
  logic [31:0]   wdata = 32'h0;
  logic [4:0]    box = 5'h00;
  logic [7:0]    hcf = 8'h00;
  logic [7:0]    hcon = 8'h00;
  logic [7:0]    hreg = 8'h00;
  logic [39:0]   herr = 40'h0;
  logic [31:0]   std = 32'h0;
  logic [87:0]   ctext = 88'h0;
  logic [87:0]   cmd_model = 88'h0;
  logic [31:0]   rdata, r = 32'hf3cb, d;
  logic [255:0]  rec_q;
  logic [7:0]    vmask;
  logic          irq, size_ok;
  int            mismatches = 0;
  int            check_count = 0;
  fdr_diag_record u_fdr_diag_record (.clk(clk), .rst(rst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .box_err(box), .head_comm_fail(hcf),
    .head_connected(hcon), .head_registered(hreg), .head_err(herr),
    .std_diag0(std[7:0]), .std_diag1(std[15:8]), .std_diag2(std[23:16]),
    .std_diag3(std[31:24]), .cmd_fail(cmd_fail), .cmd_text(ctext),
    .rec_q(rec_q));
  fdr_master_model u_fdr_master_model (.rec(rec_q), .valid_mask(vmask),
    .size_ok(size_ok));
  initial
  begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected record byte worked out from the inputs
  function automatic logic [7:0] eb(int n);
    int hi;
    hi = 0;
    for (int h = 0; h < 8; h++)
      if (hcon[h]) hi = h + 1;
    if (n < 4) return std[n*8+:8];
    if (n == 4) return fdr_pkg::UNIT_ID_DEF[15:8];
    if (n == 5) return fdr_pkg::UNIT_ID_DEF[7:0];
    if (n == 6) return 8'h20;
    if (n == 10) return hi[7:0];
    if (n == 11) return {3'h0, box[4:3], box[2] | (|hcf), box[1:0]};
    if (n >= 12 && n <= 22) return cmd_model[(n-12)*8+:8];
    if (n >= 23 && n <= 30)
      return {1'b0, hreg[n-23] & ~hcon[n-23], 1'b0, herr[(n-23)*5+:5]};
    return 8'h00;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #50000;
    mismatches++;
    test_done;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      r = nx(nx(r));
      @(posedge clk);
      box <= r[4:0];
      hcf <= r[12:5] & r[20:13];
      hcon <= r[20:13];
      hreg <= r[28:21];
      herr <= {r, r[31:24]};
      std <= ~r;
      ctext <= {r, ~r, r[23:0]};
      cmd_fail <= i[0];
      if (i[0]) cmd_model = {r, ~r, r[23:0]};
      @(posedge clk);
      cmd_fail <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      for (int n = 0; n < 32; n++)
        chk(rec_q[n*8+:8], eb(n));
      chk(vmask, (32'h1 << eb(10)) - 1);
      chk(size_ok, 1);
      rreg(8'(4 * i), d);
      chk(d, {eb(4*i+3), eb(4*i+2), eb(4*i+1), eb(4*i)});
    end
    box <= 5'h00;
    hcf <= 8'h00;
    repeat (4) @(posedge clk);
    wreg(8'h80, 32'h1f);
    wreg(8'h84, 32'h1f);
    box <= 5'h01;
    repeat (5) @(posedge clk);
    rreg(8'h80, d);
    chk(d, 32'h1);
    chk(irq, 1);
    wreg(8'h80, 32'h1);
    repeat (3) @(posedge clk);
    chk(irq, 0);
    rreg(8'h90, d);
    chk(d, 32'h0);
    rreg(8'h40, d);
    chk(d, 32'h0);
    @(posedge clk);
    ce <= 1'b0;
    box <= 5'h1a;
    repeat (4) @(posedge clk);
    #1;
    chk(rec_q[95:88], 8'h01);
    @(posedge clk);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(rec_q[95:88], eb(11));
    test_done;
  end
endmodule // tb
